/* File: pwd_pkg.sv */
// pwd_pkg: shared constants for the bus written pwm dead-time controller
// assumes: one 100 MHz device clock and an asynchronous write strobe
package pwd_pkg;
	// control latch field positions
	localparam int CTL_DT_LSB  = 0;
	localparam int CTL_DT_MSB  = 2;
	localparam int CTL_LOCK    = 3;
	localparam int CTL_DIV     = 4;
	localparam int CTL_RSVD    = 5;
	localparam int CTL_RES     = 6;
	localparam int CTL_STOP    = 7;
	// reset values
	localparam logic [7:0] CTL_RST_VAL = 8'h47;
	localparam logic [7:0] PW_RST_VAL  = 8'h00;
	// timing: clock periods per dead-time count
	localparam int         CLK_PERIOD_NS  = 10;
	localparam logic [3:0] DT_CLK_PER_CNT = 4'h2;
	// counter masks for the two resolutions
	localparam logic [7:0] CNT_MASK_8BIT = 8'hff;
	localparam logic [7:0] CNT_MASK_7BIT = 8'h7f;
endpackage

/* File: pwd_bus_latch.sv */
// pwd_bus_latch: pulse-width and control latches loaded by the write strobe
// assumes: data, select and chip select stable around the strobe rise
`timescale 1ns/100ps
module pwd_bus_latch
	import pwd_pkg::*;
(
	input  wire logic       i_wr,
	input  wire logic       i_cs_n,
	input  wire logic       i_sel,
	input  wire logic [7:0] i_data,
	input  wire logic       i_rst_n,
	output logic      [7:0] o_pulse_width_latch,
	output logic      [7:0] o_ctl,
	output logic            o_wr_tgl
);
	// pulse-width latch, loaded with select low
	always_ff @(posedge i_wr or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pulse_width_latch <= PW_RST_VAL;
		end else if (!i_cs_n && !i_sel) begin
			o_pulse_width_latch <= i_data;
		end
	end

	// control latch, loaded with select high; lock only frees stop
	always_ff @(posedge i_wr or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ctl <= CTL_RST_VAL;
		end else if (!i_cs_n && i_sel) begin
			if (o_ctl[CTL_LOCK]) begin
				o_ctl[CTL_STOP] <= i_data[CTL_STOP];
			end else begin
				o_ctl <= i_data;
			end
		end
	end

	// toggles on every accepted write so the clock side can follow
	always_ff @(posedge i_wr or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wr_tgl <= 1'b0;
		end else if (!i_cs_n) begin
			o_wr_tgl <= ~o_wr_tgl;
		end
	end
endmodule // pwd_bus_latch

/* File: pwd_top.sv */
// pwd_top: complementary pwm generator with programmable dead-time
// assumes: i_clk is the device clock; bus strobes are asynchronous to it
`timescale 1ns/100ps
module pwd_top
	import pwd_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_wr,
	input  wire logic       i_cs_n,
	input  wire logic       i_sel,
	input  wire logic [7:0] i_data,
	input  wire logic       i_hw_output_disable_n,
	output logic            o_pwm_out_high_side,
	output logic            o_pwm_out_low_side
);
	// output run state, re-armed only at a cycle start
	typedef enum logic [1:0] {
		PWD_HALTED,
		PWD_RUNNING
	} pwd_run_t;

	logic [7:0] pulse_width_latch;
	logic [7:0] ctl_latch;
	logic       wr_tgl;
	logic [2:0] tgl_sync_ff;
	logic [7:0] pw_ff;
	logic [7:0] ctl_ff;
	logic       div_en_ff;
	logic       pwm_en;
	logic [7:0] cnt_ff;
	logic [7:0] cnt_mask;
	logic       cycle_end;
	logic       cmp_raw;
	logic       cmp_ff;
	logic [3:0] dt_cnt_ff;
	logic [3:0] nxt_dt_load;
	logic [3:0] nxt_dt_cnt;
	logic [7:0] nxt_cnt;
	logic       copy_now;
	logic [7:0] nxt_pw;
	logic [7:0] nxt_ctl;
	logic       dt_done;
	logic [1:0] side_want;
	logic [1:0] side_ff;
	logic       blocked;
	logic       stop_n;
	pwd_run_t   run_state_ff;
	pwd_run_t   nxt_run_state;
	logic       run;

	pwd_bus_latch u_latch (
		.i_wr                (i_wr),
		.i_cs_n              (i_cs_n),
		.i_sel               (i_sel),
		.i_data              (i_data),
		.i_rst_n             (i_rst_n),
		.o_pulse_width_latch (pulse_width_latch),
		.o_ctl               (ctl_latch),
		.o_wr_tgl            (wr_tgl)
	);

	// write toggle crossing; third stage only feeds the edge compare
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_sync_ff <= 3'h0;
		end else begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], wr_tgl};
		end
	end

	// latches are stable once the toggle edge is seen; copy them
	assign copy_now = tgl_sync_ff[2] != tgl_sync_ff[1];
	always_comb begin
		nxt_pw  = pw_ff;
		nxt_ctl = ctl_ff;
		if (copy_now) begin
			nxt_pw            = pulse_width_latch;
			nxt_ctl           = ctl_latch;
			nxt_ctl[CTL_RSVD] = 1'b0;
		end
	end

	// clock-side copies of both latches
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pw_ff  <= PW_RST_VAL;
			ctl_ff <= CTL_RST_VAL;
		end else begin
			pw_ff  <= nxt_pw;
			ctl_ff <= nxt_ctl;
		end
	end

	// pwm clock enable: every clock, or every other when dividing
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_en_ff <= 1'b0;
		end else begin
			div_en_ff <= ~div_en_ff;
		end
	end
	assign pwm_en = !ctl_ff[CTL_DIV] || div_en_ff;

	// free-running counter, wraps at 128 or 256 pwm clocks
	assign cnt_mask  = ctl_ff[CTL_RES] ? CNT_MASK_8BIT : CNT_MASK_7BIT;
	assign cycle_end = pwm_en && ((cnt_ff & cnt_mask) == cnt_mask);
	always_comb begin
		nxt_cnt = cnt_ff;
		if (pwm_en) begin
			nxt_cnt = (cnt_ff + 8'h01) & cnt_mask;
		end
	end

	// counter flop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// comparator against pulse width, 7 significant bits in 7-bit mode
	assign cmp_raw = (cnt_ff & cnt_mask) < (pw_ff & cnt_mask);

	// dead-time counter restarts on each comparator change
	assign nxt_dt_load = 4'(ctl_ff[CTL_DT_MSB:CTL_DT_LSB] * DT_CLK_PER_CNT);
	always_comb begin
		nxt_dt_cnt = dt_cnt_ff;
		if (cmp_raw != cmp_ff) begin
			nxt_dt_cnt = nxt_dt_load;
		end else if (dt_cnt_ff != 4'h0) begin
			nxt_dt_cnt = dt_cnt_ff - 4'h1;
		end
	end

	// comparator and dead-time flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp_ff    <= 1'b0;
			dt_cnt_ff <= 4'h0;
		end else begin
			cmp_ff    <= cmp_raw;
			dt_cnt_ff <= nxt_dt_cnt;
		end
	end

	// a side turns on only with a steady comparator and dead-time over
	assign dt_done   = (dt_cnt_ff == 4'h0) && (cmp_raw == cmp_ff);
	assign side_want = {!cmp_ff, cmp_ff};

	// output flops, one per side: bit 0 high side, bit 1 low side
	for (genvar s = 0; s < 2; s++) begin : g_side
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				side_ff[s] <= 1'b0;
			end else begin
				side_ff[s] <= side_want[s] && dt_done;
			end
		end
	end

	// stop or disable halts; restart waits for the end of a cycle
	assign stop_n  = ctl_latch[CTL_STOP];
	assign blocked = !i_hw_output_disable_n || !ctl_ff[CTL_STOP];
	always_comb begin
		nxt_run_state = run_state_ff;
		case (run_state_ff)
			PWD_HALTED: begin
				if (!blocked && cycle_end) begin
					nxt_run_state = PWD_RUNNING;
				end
			end
			PWD_RUNNING: begin
				if (blocked) begin
					nxt_run_state = PWD_HALTED;
				end
			end
			default: begin
				nxt_run_state = PWD_HALTED;
			end
		endcase
	end

	// run state flop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_state_ff <= PWD_HALTED;
		end else begin
			run_state_ff <= nxt_run_state;
		end
	end
	assign run = (run_state_ff == PWD_RUNNING);

	// asynchronous gating so disable, stop and reset act without a clock
	assign o_pwm_out_high_side = side_ff[0] && run && i_hw_output_disable_n
		&& stop_n && i_rst_n;
	assign o_pwm_out_low_side  = side_ff[1] && run && i_hw_output_disable_n
		&& stop_n && i_rst_n;
endmodule // pwd_top

/* File: pwd_top_assertions.sv */
// pwd_chk: output safety checks on pwd_top ports
// assumes: one clock, active-low async reset
`timescale 1ns/100ps
module pwd_chk
	import pwd_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_wr,
	input wire logic       i_cs_n,
	input wire logic       i_sel,
	input wire logic [7:0] i_data,
	input wire logic       i_hw_output_disable_n,
	input wire logic       o_pwm_out_high_side,
	input wire logic       o_pwm_out_low_side
);
	wire logic h = o_pwm_out_high_side;
	wire logic l = o_pwm_out_low_side;
	wire logic d = i_hw_output_disable_n;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// no overlap, a gap before each rise
	property p_nov; !(h && l); endproperty
	a_nov: assert property (p_nov) else $error("overlap");
	property p_dtl; $rose(l) |-> !$past(h); endproperty
	a_dtl: assert property (p_dtl) else $error("gap");
	property p_dth; $rose(h) |-> !$past(l); endproperty
	a_dth: assert property (p_dth) else $error("gap");
	// disable, stop and reset hold both low
	property p_dis; !d |-> !h && !l; endproperty
	a_dis: assert property (p_dis) else $error("disable");
	property p_rel; $rose(d) |-> !h && !l; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_rst; disable iff (1'b0) !i_rst_n |-> !h && !l; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_boot; $rose(i_rst_n) |-> (!h && !l) [*4]; endproperty
	a_boot: assert property (p_boot) else $error("boot");
	property p_stop; $rose(i_wr) && !i_cs_n && i_sel && !i_data[CTL_STOP]
		|-> (!h && !l) [*4]; endproperty
	a_stop: assert property (p_stop) else $error("stop");
	c_hi: cover property ($rose(h));
	c_lo: cover property ($rose(l));
	c_dis: cover property ($rose(d));
endmodule // pwd_chk
bind pwd_top pwd_chk pwd_chk_i (.*);

/* File: pwd_host.sv */
// pwd_host: write-bus master model for the latch port
// assumes: bench calls wr_byte; lines move on falling edges
`timescale 1ns/100ps
module pwd_host (
	input  wire logic       i_clk,
	output logic            o_wr = 1'b1,
	output logic            o_cs_n = 1'b1,
	output logic            o_sel = 1'b0,
	output logic      [7:0] o_data = 8'h00
);
	// one write, strobe rise takes the byte, then release
	task automatic wr_byte(input logic c, s, input logic [7:0] v);
		@(negedge i_clk);
		{o_cs_n, o_sel, o_data, o_wr} = {c, s, v, 1'b0};
		@(negedge i_clk);
		o_wr = 1'b1;
		repeat (2) @(negedge i_clk);
		{o_cs_n, o_data} = {1'b1, ~v}; // stale byte not left
		repeat (4) @(negedge i_clk);
	endtask
endmodule // pwd_host

/* File: tb_bus_pwm_deadtime_controller.sv */
// tb: duty, dead-time, lock and disable checks
// assumes: pwd_top, pwd_host and bound checker
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module tb_bus_pwm_deadtime_controller;
	import pwd_pkg::*;
	logic       i_clk = 1'b0, i_rst_n = 1'b0, dis_n = 1'b1, h, l, wr, cs_n, sel;
	logic [7:0] dat, pw = PW_RST_VAL, ctl = CTL_RST_VAL;
	int         num_errors = 0, comparisons = 0, cyc = 0;
	pwd_host pwd_host_i (.i_clk, .o_wr(wr), .o_cs_n(cs_n), .o_sel(sel),
		.o_data(dat));
	pwd_top pwd_top_i (.i_clk, .i_rst_n, .i_wr(wr), .i_cs_n(cs_n), .i_sel(sel),
		.i_data(dat), .i_hw_output_disable_n(dis_n),
		.o_pwm_out_high_side(h), .o_pwm_out_low_side(l));
	always #5 i_clk = ~i_clk;
	// hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			final_report();
		end
	end
	function automatic logic [11:0] expc(input bit hi);
		int m, p, on, dt;
		m = ctl[CTL_DIV] ? 2 : 1;
		p = (ctl[CTL_RES] ? 256 : 128) * m;
		on = (ctl[CTL_RES] ? pw : pw[6:0]) * m;
		on = hi ? on : p - on;
		// plus one clock for the comparator flop before a side turns on
		dt = 2 * ctl[CTL_DT_MSB:CTL_DT_LSB] + 1;
		on = (on == p) ? p : (on > dt) ? on - dt : 0;
		return (ctl[CTL_STOP] && dis_n) ? 12'(on) : 12'h000;
	endfunction
	// settle, then sum both sides over one period
	task automatic meas(input string nm);
		int p;
		logic [11:0] ch, cl;
		p = (ctl[CTL_RES] ? 256 : 128) * (ctl[CTL_DIV] ? 2 : 1);
		{ch, cl} = 24'h00_0000;
		repeat (2 * p + 8) @(negedge i_clk);
		repeat (p) begin
			@(negedge i_clk);
			ch = ch + 12'(h);
			cl = cl + 12'(l);
		end
		`CHK(ch, expc(1))
		`CHK(cl, expc(0))
		$display("%s done", nm);
	endtask
	task automatic mwr(input logic c, s, input logic [7:0] v);
		if (!c && i_rst_n && s) ctl = ctl[CTL_LOCK] ? {v[7], ctl[6:0]} : v;
		if (!c && i_rst_n && !s) pw = v;
		pwd_host_i.wr_byte(c, s, v);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(21954));
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		meas("boot");
		for (int k = 0; k < 4; k++) begin
			mwr(0, 1, {1'b1, 1'($urandom), 1'b0, 1'($urandom), 1'b0, 3'($urandom)});
			mwr(0, 0, 8'(16 + $urandom % 96));
			meas("random");
		end
		dis_n = 1'b0;
		meas("disable");
		dis_n = 1'b1;
		meas("release");
		mwr(0, 1, 8'hcb);
		mwr(0, 1, 8'hc0);
		meas("lock");
		mwr(1, 0, 8'h20);
		mwr(1, 1, 8'h4b);
		meas("deselect");
		mwr(0, 1, 8'h40);
		meas("stop");
		i_rst_n = 1'b0;
		mwr(0, 1, 8'hc0);
		{ctl, pw} = {CTL_RST_VAL, PW_RST_VAL};
		i_rst_n = 1'b1;
		meas("reset");
		mwr(0, 1, 8'hc7);
		meas("defaults");
		mwr(0, 1, 8'hc2);
		mwr(0, 0, 8'h50);
		meas("unlock");
		final_report();
	end
endmodule // tb_bus_pwm_deadtime_controller
